/* File: rtl/pulse_channel0_pkg.sv */
// constants, offsets and types shared by the pulse channel 0 block
package pulse_channel0_pkg;

    // ------------------------------------------------------------------
    // register byte offsets on the apb bus
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 8;
    localparam logic [7:0]  CTRL_OFS    = 8'h20;
    localparam logic [7:0]  PRELOAD_OFS = 8'h24;
    localparam logic [7:0]  CH1_OFS     = 8'h28;
    localparam logic [7:0]  PC_DIR_OFS  = 8'h2c;
    localparam logic [7:0]  PC_DATA_OFS = 8'h30;
    localparam logic [7:0]  PC_PULL_OFS = 8'h34;

    // ------------------------------------------------------------------
    // control and channel 1 register field positions
    // ------------------------------------------------------------------
    localparam int unsigned CMP0_EN_BIT    = 0;
    localparam int unsigned CMP1_EN_BIT    = 1;
    localparam int unsigned PSC_LSB        = 2;
    localparam int unsigned PSC_W          = 3;
    localparam int unsigned STOP_EN_BIT    = 5;
    localparam int unsigned RESTART_EN_BIT = 6;
    localparam int unsigned SOFT_TRIG_BIT  = 7;
    localparam int unsigned SWAP_BIT       = 0;
    localparam int unsigned CTRL_STORE_W   = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] CTRL_RST    = 7'h00;
    localparam logic [7:0] PRELOAD_RST = 8'h00;
    localparam logic       SWAP_RST    = 1'b0;
    localparam logic [3:0] PC_DIR_RST  = 4'hf;
    localparam logic [3:0] PC_DATA_RST = 4'hf;
    localparam logic [3:0] PC_PULL_RST = 4'h0;

    // ------------------------------------------------------------------
    // timer and prescaler
    // ------------------------------------------------------------------
    localparam int unsigned DIV_W     = 7;
    localparam int unsigned COUNT_W   = 8;
    localparam logic [7:0]  COUNT_TOP = 8'hff;

    // ------------------------------------------------------------------
    // synchroniser lanes
    // ------------------------------------------------------------------
    localparam int unsigned SYNC_W    = 7;
    localparam int unsigned IN_IRQ1   = 0;
    localparam int unsigned IN_CMP0   = 1;
    localparam int unsigned IN_CMP1   = 2;
    localparam int unsigned IN_PC_LSB = 3;
    localparam int unsigned PC_W      = 4;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } run_state_e;

endpackage : pulse_channel0_pkg

/* File: rtl/prescale_if.sv */
// carrier between the channel control and its prescaler
`timescale 1ns/1ps
interface prescale_if;
    import pulse_channel0_pkg::*;
    logic [PSC_W-1:0] sel;
    logic             clr;
    logic             tick;
    modport ctrl (output sel, output clr, input tick);
    modport div  (input sel, input clr, output tick);
endinterface : prescale_if

/* File: rtl/prescale_divider.sv */
// power-of-two prescaler producing a one-cycle count enable
`timescale 1ns/1ps
module prescale_divider
    import pulse_channel0_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // control side
    prescale_if.div   pif
);

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
    } div_s;

    div_s q;
    div_s d;

    function automatic logic [DIV_W-1:0] sel_mask(input logic [PSC_W-1:0] s);
        logic [DIV_W:0] one_hot;
        one_hot  = '0;
        one_hot  = (DIV_W+1)'(1) << s;
        sel_mask = DIV_W'(one_hot - (DIV_W+1)'(1));
    endfunction : sel_mask

    // clear restarts the phase so the first tick lands 2**sel cycles later
    always_comb begin
        d = q;
        if (pif.clr) begin
            d.cnt = '0;
        end else begin
            d.cnt = q.cnt + DIV_W'(1);
        end
        pif.tick = ((q.cnt & sel_mask(pif.sel)) == sel_mask(pif.sel));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : prescale_divider

/* File: rtl/pulse_channel0_control.sv */
// pulse channel 0 control: apb registers, triggers, timer and port c
//
// Notes on behaviour
// - comparator0_en low: comparator 0 off, port_c lines 0..2 plain gpio.
// - comparator0_en high: lines 0,1 comparator inputs, line 2 output, undriven.
// - comparator1_en low: comparator 1 off, port_c_line3 plain gpio.
// - comparator1_en high: line 3 undriven, reads return comparator1_out while dir bit 3 is set.
// - counter clock is system clock divided by two to the prescale code.
// - stop enabled: falling edge of stop_trigger_src stops the timer.
// - stop source is comparator0_out or ext_irq1_pin, chosen by swap bit.
// - stop disabled: stop edges ignored; only software clear or overflow stops.
// - restart enabled: falling edge of comparator1_out restarts the timer.
// - restart disabled: edges ignored; only software set restarts.
// - writing one to the soft trigger starts counting.
// - soft trigger clears itself on overflow or any stop.
// - writing zero to the soft trigger stops counting.
// - while counting, restart edges and software sets are ignored.
// - soft trigger reads back the current run status.
// - swap 0: stop from ext_irq1_pin; swap 1: stop from comparator0_out.
// - count up from preload to overflow, then reload preload and halt.
// - preload zero gives a pulse of 256 prescaled periods.
`timescale 1ns/1ps
module pulse_channel0_control
    import pulse_channel0_pkg::*;
#(
    parameter logic ACTIVE_HIGH = 1'b1
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // trigger inputs from pins and comparators
    input  wire logic              ext_irq1_pin,
    input  wire logic              comparator0_out,
    input  wire logic              comparator1_out,
    // comparator enables to the analog side
    output logic                   comparator0_en,
    output logic                   comparator1_en,
    // port c lines 0..3
    input  wire logic [PC_W-1:0]   port_c_in,
    output logic      [PC_W-1:0]   port_c_out,
    output logic      [PC_W-1:0]   port_c_oe,
    output logic      [PC_W-1:0]   port_c_pull_en,
    // channel 0 pulse
    output logic                   pulse_channel0
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [SYNC_W-1:0]       s1;
        logic [SYNC_W-1:0]       s2;
        logic [SYNC_W-1:0]       s3;
        logic [SYNC_W-1:0]       stab;
        logic [CTRL_STORE_W-1:0] ctrl;
        logic [COUNT_W-1:0]      preload;
        logic                    swap;
        logic [PC_W-1:0]         dir;
        logic [PC_W-1:0]         latch;
        logic [PC_W-1:0]         pull;
        run_state_e              state;
        logic [COUNT_W-1:0]      count;
        logic                    pulse;
        logic [PC_W-1:0]         pc_oe;
        logic [PC_W-1:0]         pc_pu;
        logic                    cmp0_o;
        logic                    cmp1_o;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } ctl_s;

    ctl_s q;
    ctl_s d;

    prescale_if pif ();

    prescale_divider u_div (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pif     (pif)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == CTRL_OFS) || (a == PRELOAD_OFS) ||
                    (a == CH1_OFS) || (a == PC_DIR_OFS) ||
                    (a == PC_DATA_OFS) || (a == PC_PULL_OFS);
    endfunction : is_mapped

    function automatic logic stop_pick(input logic [SYNC_W-1:0] st,
                                       input logic              sw);
        stop_pick = sw ? st[IN_CMP0] : st[IN_IRQ1];
    endfunction : stop_pick

    logic              setup_ph;
    logic              wr_acc;
    logic              wr_ok;
    logic              soft_set;
    logic              soft_clr;
    logic              stop_fall;
    logic              restart_fall;
    logic              start;
    logic [PC_W-1:0]   port_rd;
    logic [31:0]       rd_word;
    logic [SYNC_W-1:0] diff;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        d            = q;
        start        = 1'b0;
        rd_word      = '0;
        port_rd      = '0;

        // three-stage synchronisers; a level counts once stages 2 and 3 agree
        d.s1   = {port_c_in, comparator1_out, comparator0_out, ext_irq1_pin};
        d.s2   = q.s1;
        d.s3   = q.s2;
        diff   = q.s2 ^ q.s3;
        d.stab = (q.s2 & ~diff) | (q.stab & diff);

        // both samples use q.swap, so a swap change cannot fake an edge
        stop_fall    = stop_pick(q.stab, q.swap) &
                       ~stop_pick(d.stab, q.swap);
        restart_fall = q.stab[IN_CMP1] & ~d.stab[IN_CMP1];

        // apb: zero wait states, pready raised for the access phase only
        setup_ph = psel & ~penable;
        wr_acc   = psel & penable & pwrite & q.pready;
        wr_ok    = wr_acc & ~q.pslverr;
        soft_set = wr_ok && (paddr == CTRL_OFS) && pwdata[SOFT_TRIG_BIT];
        soft_clr = wr_ok && (paddr == CTRL_OFS) && !pwdata[SOFT_TRIG_BIT];

        // port data read: pad, latch or comparator output
        for (int i = 0; i < PC_W; i++) begin
            port_rd[i] = q.dir[i] ? q.stab[IN_PC_LSB+i] : q.latch[i];
        end
        if (q.ctrl[CMP0_EN_BIT] && q.dir[2]) begin
            port_rd[2] = q.stab[IN_CMP0];
        end
        if (q.ctrl[CMP1_EN_BIT] && q.dir[3]) begin
            port_rd[3] = q.stab[IN_CMP1];
        end

        // read decode
        if (paddr == CTRL_OFS) begin
            rd_word = {24'h000000, (q.state == ST_RUN), q.ctrl};
        end else if (paddr == PRELOAD_OFS) begin
            rd_word = {24'h000000, q.preload};
        end else if (paddr == CH1_OFS) begin
            rd_word = {31'h00000000, q.swap};
        end else if (paddr == PC_DIR_OFS) begin
            rd_word = {28'h0000000, q.dir};
        end else if (paddr == PC_DATA_OFS) begin
            rd_word = {28'h0000000, port_rd};
        end else if (paddr == PC_PULL_OFS) begin
            rd_word = {28'h0000000, q.pull};
        end else begin
            rd_word = '0;
        end

        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        if (setup_ph) begin
            d.pready  = 1'b1;
            d.pslverr = ~is_mapped(paddr);
            d.prdata  = pwrite ? 32'h00000000 : rd_word;
        end

        // register writes take effect at the access edge
        if (wr_ok) begin
            if (paddr == CTRL_OFS) begin
                d.ctrl = pwdata[CTRL_STORE_W-1:0];
            end else if (paddr == PRELOAD_OFS) begin
                d.preload = pwdata[COUNT_W-1:0];
            end else if (paddr == CH1_OFS) begin
                d.swap = pwdata[SWAP_BIT];
            end else if (paddr == PC_DIR_OFS) begin
                d.dir = pwdata[PC_W-1:0];
            end else if (paddr == PC_DATA_OFS) begin
                d.latch = pwdata[PC_W-1:0];
            end else if (paddr == PC_PULL_OFS) begin
                d.pull = pwdata[PC_W-1:0];
            end
        end

        // --------------------------------------------------------------
        // channel 0 timer
        // --------------------------------------------------------------
        case (q.state)
            ST_IDLE: begin
                // hardware restart beats a software clear in the same cycle
                if (soft_set) begin
                    start = 1'b1;
                end else if (q.ctrl[RESTART_EN_BIT] && restart_fall) begin
                    start = 1'b1;
                end
                if (start) begin
                    d.state = ST_RUN;
                    d.count = q.preload;
                end
            end
            ST_RUN: begin
                // soft_set and restart edges ignored while counting
                if (soft_clr) begin
                    d.state = ST_IDLE;
                end else if (q.ctrl[STOP_EN_BIT] && stop_fall) begin
                    d.state = ST_IDLE;
                end else if (pif.tick) begin
                    if (q.count == COUNT_TOP) begin
                        d.count = q.preload;
                        d.state = ST_IDLE;
                    end else begin
                        d.count = q.count + COUNT_W'(1);
                    end
                end
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase

        // polarity is a build-time choice, not software-visible
        d.pulse = (d.state == ST_RUN) ? ACTIVE_HIGH : ~ACTIVE_HIGH;

        // --------------------------------------------------------------
        // port c pin control
        // --------------------------------------------------------------
        d.cmp0_o = d.ctrl[CMP0_EN_BIT];
        d.cmp1_o = d.ctrl[CMP1_EN_BIT];
        d.pc_oe  = ~d.dir;
        d.pc_pu  = d.pull;
        if (d.ctrl[CMP0_EN_BIT]) begin
            // analog inputs and comparator output: no digital drive or pull
            d.pc_oe[2:0] = 3'h0;
            d.pc_pu[2:0] = 3'h0;
        end
        if (d.ctrl[CMP1_EN_BIT]) begin
            d.pc_oe[3] = 1'b0;
            d.pc_pu[3] = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // prescaler hookup
    // ------------------------------------------------------------------
    assign pif.sel = q.ctrl[PSC_LSB +: PSC_W];
    assign pif.clr = start;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q         <= '0;
            q.ctrl    <= CTRL_RST;
            q.preload <= PRELOAD_RST;
            q.swap    <= SWAP_RST;
            q.dir     <= PC_DIR_RST;
            q.latch   <= PC_DATA_RST;
            q.pull    <= PC_PULL_RST;
            q.state   <= ST_IDLE;
            q.pulse   <= ~ACTIVE_HIGH;
            q.pc_pu   <= PC_PULL_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata         = q.prdata;
    assign pready         = q.pready;
    assign pslverr        = q.pslverr;
    assign comparator0_en = q.cmp0_o;
    assign comparator1_en = q.cmp1_o;
    assign port_c_out     = q.latch;
    assign port_c_oe      = q.pc_oe;
    assign port_c_pull_en = q.pc_pu;
    assign pulse_channel0 = q.pulse;

endmodule : pulse_channel0_control

/* File: testbench/pulse_channel0_sva.sv */
// assertion checker for the pulse channel 0 control block
`timescale 1ns/1ps
module pulse_channel0_sva
    import pulse_channel0_pkg::*;
#(
    parameter logic ACTIVE_HIGH = 1'b1
)
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // apb slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // pins
    input wire logic              comparator0_en,
    input wire logic              comparator1_en,
    input wire logic [PC_W-1:0]   port_c_oe,
    input wire logic [PC_W-1:0]   port_c_pull_en,
    input wire logic              pulse_channel0
);
    logic ctrl_wr;
    logic run;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == CTRL_OFS;
    assign run     = pulse_channel0 == ACTIVE_HIGH;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_cmp_enables: assert property (ctrl_wr |=>
        {comparator1_en, comparator0_en} == $past(pwdata[1:0]))
        else $error("comparator enables not from ctrl write");
    chk_cmp0_release: assert property (comparator0_en |->
        port_c_oe[2:0] == 3'h0 && port_c_pull_en[2:0] == 3'h0)
        else $error("line 2 still driven with comparator 0 on");
    chk_cmp1_release: assert property (comparator1_en |->
        !port_c_oe[3] && !port_c_pull_en[3])
        else $error("line 3 still driven with comparator 1 on");
    chk_soft_start: assert property (ctrl_wr && pwdata[7] && !run |=> run)
        else $error("soft start did not start");
    chk_soft_stop: assert property (ctrl_wr && !pwdata[7] && run |=> !run)
        else $error("soft stop did not stop");
    chk_status_read: assert property (pready && !pwrite &&
        paddr == CTRL_OFS |-> prdata[7] == $past(run))
        else $error("status bit differs from run state");

    cover property (ctrl_wr && pwdata[7] && !run);
    cover property (run ##1 !run);
    cover property (pslverr);
endmodule : pulse_channel0_sva

bind pulse_channel0_control pulse_channel0_sva #(.ACTIVE_HIGH(ACTIVE_HIGH))
    u_pulse_channel0_sva (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator0_en(comparator0_en), .comparator1_en(comparator1_en),
    .port_c_oe(port_c_oe), .port_c_pull_en(port_c_pull_en),
    .pulse_channel0(pulse_channel0));

/* File: testbench/trigger_sources.sv */
// model of the comparators, the interrupt pin and the port c pads
`timescale 1ns/1ps
module trigger_sources
    import pulse_channel0_pkg::*;
(
    // levels commanded by the bench
    input wire logic            irq_lvl,
    input wire logic            cmp0_lvl,
    input wire logic            cmp1_lvl,
    input wire logic [PC_W-1:0] pad_ext,
    // device side
    input wire logic            comparator0_en,
    input wire logic            comparator1_en,
    input wire logic [PC_W-1:0] port_c_out,
    input wire logic [PC_W-1:0] port_c_oe,
    input wire logic [PC_W-1:0] port_c_pull_en,
    output logic                ext_irq1_pin,
    output logic                comparator0_out,
    output logic                comparator1_out,
    output logic [PC_W-1:0]     port_c_in
);
    // a disabled comparator rests high, so it never offers a falling edge
    assign comparator0_out = comparator0_en ? cmp0_lvl : 1'b1;
    assign comparator1_out = comparator1_en ? cmp1_lvl : 1'b1;
    assign ext_irq1_pin    = irq_lvl;
    always_comb begin
        for (int i = 0; i < PC_W; i++) begin
            port_c_in[i] = port_c_oe[i] ? port_c_out[i] :
                           port_c_pull_en[i] ? 1'b1 : pad_ext[i];
        end
        // an enabled comparator drives its own output pad
        if (comparator0_en) port_c_in[2] = comparator0_out;
        if (comparator1_en) port_c_in[3] = comparator1_out;
    end
endmodule : trigger_sources

/* File: testbench/tb_top.sv */
// self-checking bench for the pulse channel 0 control block
`timescale 1ns/1ps
module tb_top
    import pulse_channel0_pkg::*;
;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic ext_irq1_pin, comparator0_out, comparator1_out;
    logic comparator0_en, comparator1_en, pulse_channel0, err;
    logic [PC_W-1:0] port_c_in, port_c_out, port_c_oe, port_c_pull_en;
    logic irq_lvl, cmp0_lvl, cmp1_lvl;
    logic [PC_W-1:0] pad_ext;
    int n_fail, checks, cyc;

    pulse_channel0_control u_pulse_channel0_control (.clk_sys(clk_sys),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_irq1_pin(ext_irq1_pin),
        .comparator0_out(comparator0_out), .comparator1_out(comparator1_out),
        .comparator0_en(comparator0_en), .comparator1_en(comparator1_en),
        .port_c_in(port_c_in), .port_c_out(port_c_out),
        .port_c_oe(port_c_oe), .port_c_pull_en(port_c_pull_en),
        .pulse_channel0(pulse_channel0));
    trigger_sources u_trigger_sources (.irq_lvl(irq_lvl), .cmp0_lvl(cmp0_lvl),
        .cmp1_lvl(cmp1_lvl), .pad_ext(pad_ext),
        .comparator0_en(comparator0_en), .comparator1_en(comparator1_en),
        .port_c_out(port_c_out), .port_c_oe(port_c_oe),
        .port_c_pull_en(port_c_pull_en), .ext_irq1_pin(ext_irq1_pin),
        .comparator0_out(comparator0_out), .comparator1_out(comparator1_out),
        .port_c_in(port_c_in));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    // a hung handshake ends here after far more than the tests need
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            give_verdict();
        end
    end

    task chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdchk(string what, logic [7:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdchk

    task measure(output logic [31:0] n);
        n = 0;
        @(posedge clk_sys);
        while (pulse_channel0 === 1'b1 && n < 40000) begin
            n++;
            @(posedge clk_sys);
        end
    endtask : measure

    task t_reset;
        chk("pulse", pulse_channel0, 32'h0);
        chk("oe", port_c_oe, 32'h0);
        chk("pc_out", port_c_out, 32'hf);
        rdchk("ctrl", CTRL_OFS, 32'h0);
        rdchk("hole", 8'h3c, 32'h0);
        chk("slverr", err, 32'h1);
    endtask : t_reset

    task t_pins;
        wr(PC_DIR_OFS, 32'h0);
        wr(PC_DATA_OFS, 32'h5);
        wr(PC_PULL_OFS, 32'hf);
        wr(CTRL_OFS, 32'h1);
        // pin controls move at the access edge, with the register write
        @(posedge clk_sys);
        chk("pc_out", port_c_out, 32'h5);
        chk("oe0", port_c_oe, 32'h8);
        chk("pull0", port_c_pull_en, 32'h8);
        wr(CTRL_OFS, 32'h2);
        @(posedge clk_sys);
        chk("oe1", port_c_oe, 32'h7);
        wr(PC_DIR_OFS, 32'hf);
        wr(CTRL_OFS, 32'h3);
        cmp0_lvl <= 1'b1;
        cmp1_lvl <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk("pc_a", PC_DATA_OFS, 32'h4);
        cmp0_lvl <= 1'b0;
        cmp1_lvl <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdchk("pc_b", PC_DATA_OFS, 32'h8);
        wr(CTRL_OFS, 32'h0);
        wr(PC_PULL_OFS, 32'h0);
        cmp0_lvl <= 1'b1;
    endtask : t_pins

    task t_width;
        logic [31:0] n;
        for (int p = 0; p < 8; p++) begin
            wr(PRELOAD_OFS, 32'hf0);
            wr(CTRL_OFS, 32'h80 + 32'(p * 4));
            measure(n);
            chk("width", n, 32'(16 << p));
            rdchk("ctrl_end", CTRL_OFS, 32'(p * 4));
        end
        wr(PRELOAD_OFS, 32'h0);
        wr(CTRL_OFS, 32'h80);
        measure(n);
        chk("width0", n, 32'd256);
    endtask : t_width

    task t_soft;
        logic [31:0] n;
        wr(PRELOAD_OFS, 32'hf0);
        rdchk("preload", PRELOAD_OFS, 32'hf0);
        wr(CTRL_OFS, 32'h80);
        // a second start three cycles in must leave the count alone
        wr(CTRL_OFS, 32'h80);
        chk("rerun", pulse_channel0, 32'h1);
        measure(n);
        chk("rerun_len", n, 32'd13);
        wr(CTRL_OFS, 32'h9c);
        rdchk("run", CTRL_OFS, 32'h9c);
        wr(CTRL_OFS, 32'h1c);
        @(posedge clk_sys);
        chk("stopped", pulse_channel0, 32'h0);
        rdchk("idle", CTRL_OFS, 32'h1c);
    endtask : t_soft

    task src(logic sel, logic lvl);
        if (sel) cmp0_lvl <= lvl;
        else irq_lvl <= lvl;
    endtask : src

    task t_stop;
        for (int s = 0; s < 2; s++) begin
            wr(CTRL_OFS, 32'h0);
            wr(CH1_OFS, 32'(s));
            rdchk("swap", CH1_OFS, 32'(s));
            wr(CTRL_OFS, 32'h9f);
            src(s[0], 1'b0);
            repeat (8) @(posedge clk_sys);
            chk("no_stop", pulse_channel0, 32'h1);
            src(s[0], 1'b1);
            wr(CTRL_OFS, 32'hbf);
            src(!s[0], 1'b0);
            repeat (8) @(posedge clk_sys);
            chk("other_src", pulse_channel0, 32'h1);
            src(!s[0], 1'b1);
            src(s[0], 1'b0);
            repeat (8) @(posedge clk_sys);
            chk("hw_stop", pulse_channel0, 32'h0);
            src(s[0], 1'b1);
        end
        wr(CTRL_OFS, 32'h0);
        wr(CH1_OFS, 32'h0);
    endtask : t_stop

    task t_restart;
        wr(CTRL_OFS, 32'h1f);
        cmp1_lvl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("no_start", pulse_channel0, 32'h0);
        cmp1_lvl <= 1'b1;
        wr(CTRL_OFS, 32'h5f);
        cmp1_lvl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        chk("hw_start", pulse_channel0, 32'h1);
        rdchk("hw_run", CTRL_OFS, 32'hdf);
        cmp1_lvl <= 1'b1;
        wr(CTRL_OFS, 32'h0);
    endtask : t_restart

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; irq_lvl = 1'b1; cmp0_lvl = 1'b1;
        cmp1_lvl = 1'b1; pad_ext = '0; n_fail = 0; checks = 0; cyc = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_pins();
        t_width();
        t_soft();
        t_stop();
        t_restart();
        give_verdict();
    end
endmodule : tb_top
